// ==== module_power_reset_control.sv ====
// power button, reset button and carrier reset sequencer of the module
//
// Contract
// - a falling edge on power_button_n wakes the system out of soft-off
// - reset_button_n starts a reset on its falling edge, not its level
// - a reset button held low does not hold the system in reset
// - carrier_reset_n is an active-low reset output to the carrier
// - button, supply-good low, main supply low, watchdog or software cause reset
// - supply_good high means main power good, low means not good
// - suspend_imminent_n goes low ahead of entering any suspend state
// - suspend_to_ram_n is low only while in suspend-to-RAM
// - watchdog_expired signals that a watchdog time-out occurred
// - soft_off_state_n is low while in soft-off
`timescale 1ns/1ps
`include "mprc_map.svh"
module module_power_reset_control (
  // clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                clkEn,
  // carrier pins
  input  wire logic                power_button_n,
  input  wire logic                reset_button_n,
  input  wire logic                supply_good,
  input  wire logic                mainSupplyLow,
  // chipset events, same clock
  input  wire logic                watchdogTimeout,
  input  wire logic                softResetReq,
  input  wire logic                suspendReq,
  input  wire logic                softOffReq,
  input  wire logic                wakeReq,
  // outputs to carrier
  output logic                     carrier_reset_n,
  output logic                     suspend_imminent_n,
  output logic                     suspend_to_ram_n,
  output logic                     soft_off_state_n,
  output logic                     watchdog_expired,
  output mprc_pkg::mprc_pwr_e      powerState
);
  import mprc_pkg::*;

  mprc_sync_if syncBus ();

  // idle pins: buttons released, supply good, main supply not low
  localparam logic [3:0] PinIdle = 4'h7;
  // hold and lead counts, cut to the counter width on purpose
  localparam mprc_cnt_t  HoldCyc = mprc_cnt_t'(`MPRC_RST_HOLD_CYC);
  localparam mprc_cnt_t  LeadCyc = mprc_cnt_t'(`MPRC_SUS_LEAD_CYC);

  mprc_sync #(
    .IdleLevel (PinIdle)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .rawPins  ({mainSupplyLow, supply_good, reset_button_n, power_button_n}),
    .syncOut  (syncBus)
  );

  logic pwrBtnS;
  logic rstBtnS;
  logic supplyGoodS;
  logic mainLowS;
  assign pwrBtnS     = syncBus.level[0];
  assign rstBtnS     = syncBus.level[1];
  assign supplyGoodS = syncBus.level[2];
  assign mainLowS    = syncBus.level[3];

  // pin history for edge detect, read only after the synchroniser
  logic      pwrPrev;
  logic      rstPrev;
  mprc_pwr_e state;
  mprc_cnt_t leadCnt;
  mprc_cnt_t holdCnt;
  logic      resetOut;
  logic      wdFlag;
  logic      next_pwrPrev;
  logic      next_rstPrev;
  mprc_pwr_e next_state;
  mprc_cnt_t next_leadCnt;
  mprc_cnt_t next_holdCnt;
  logic      next_resetOut;
  logic      next_wdFlag;
  logic      pwrFall;
  logic      rstFall;
  logic      resetCause;
  logic      levelCause;

  always_comb begin
    pwrFall = pwrPrev & ~pwrBtnS;
    rstFall = rstPrev & ~rstBtnS;
    // a held button is not a level cause, so it cannot stretch the reset
    levelCause = ~supplyGoodS | mainLowS;
    resetCause = rstFall | levelCause | watchdogTimeout | softResetReq;
    next_pwrPrev  = pwrBtnS;
    next_rstPrev  = rstBtnS;
    next_state    = state;
    next_leadCnt  = leadCnt;
    next_holdCnt  = holdCnt;
    next_resetOut = resetOut;
    next_wdFlag   = wdFlag | watchdogTimeout;
    case (state)
      MPRC_OFF: begin
        next_resetOut = 1'b1;
        // press width is the carrier's duty; only the edge is acted on
        if (pwrFall) begin
          next_state = MPRC_WAKE;
        end
      end
      MPRC_WAKE: begin
        next_resetOut = 1'b1;
        next_holdCnt  = HoldCyc;
        if (supplyGoodS && !mainLowS) begin
          next_state = MPRC_RUN;
        end
      end
      MPRC_RUN: begin
        if (resetCause) begin
          next_resetOut = 1'b1;
          next_holdCnt  = HoldCyc;
        end else if (holdCnt != '0) begin
          next_holdCnt = holdCnt - 1'b1;
        end else if (!levelCause) begin
          next_resetOut = 1'b0;
        end
        if (!resetOut && !resetCause) begin
          if (softOffReq) begin
            next_state   = MPRC_PRE_OFF;
            next_leadCnt = LeadCyc;
          end else if (suspendReq) begin
            next_state   = MPRC_PRE_S3;
            next_leadCnt = LeadCyc;
          end
        end
      end
      MPRC_PRE_S3, MPRC_PRE_OFF: begin
        // a cause during the lead resets at once, not only at the state change
        if (resetCause) begin
          next_resetOut = 1'b1;
        end
        // lead time lets bus peripherals park before power goes
        if (leadCnt != '0) begin
          next_leadCnt = leadCnt - 1'b1;
        end else begin
          next_resetOut = 1'b1;
          next_state    = (state == MPRC_PRE_S3) ? MPRC_S3 : MPRC_OFF;
        end
      end
      MPRC_S3: begin
        next_resetOut = 1'b1;
        if (pwrFall || wakeReq) begin
          next_state = MPRC_WAKE;
        end
      end
      default: begin
        next_state    = MPRC_OFF;
        next_resetOut = 1'b1;
      end
    endcase
    if (!clkEn) begin
      next_pwrPrev  = pwrPrev;
      next_rstPrev  = rstPrev;
      next_state    = state;
      next_leadCnt  = leadCnt;
      next_holdCnt  = holdCnt;
      next_resetOut = resetOut;
      next_wdFlag   = wdFlag;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrPrev  <= 1'b1;
      rstPrev  <= 1'b1;
      state    <= MPRC_OFF;
      leadCnt  <= '0;
      holdCnt  <= '0;
      resetOut <= 1'b1;
      wdFlag   <= 1'b0;
    end else begin
      pwrPrev  <= next_pwrPrev;
      rstPrev  <= next_rstPrev;
      state    <= next_state;
      leadCnt  <= next_leadCnt;
      holdCnt  <= next_holdCnt;
      resetOut <= next_resetOut;
      wdFlag   <= next_wdFlag;
    end
  end

  // outputs registered
  logic sStat;
  logic sRam;
  logic sOff;
  logic next_sStat;
  logic next_sRam;
  logic next_sOff;

  always_comb begin
    next_sStat = ~(next_state == MPRC_PRE_S3 || next_state == MPRC_PRE_OFF ||
                   next_state == MPRC_S3 || next_state == MPRC_OFF);
    next_sRam  = (next_state != MPRC_S3);
    next_sOff  = (next_state != MPRC_OFF);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sStat <= 1'b0;
      sRam  <= 1'b1;
      sOff  <= 1'b0;
    end else begin
      sStat <= next_sStat;
      sRam  <= next_sRam;
      sOff  <= next_sOff;
    end
  end

  assign carrier_reset_n    = ~resetOut;
  assign suspend_imminent_n = sStat;
  assign suspend_to_ram_n   = sRam;
  assign soft_off_state_n   = sOff;
  assign watchdog_expired   = wdFlag;
  assign powerState         = state;
endmodule

// ==== module_power_reset_control_tb_top.sv ====
// self-checking bench for the power and reset sequencer
`timescale 1ns/1ps
module module_power_reset_control_tb_top;
  import mprc_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, wakeReq = 1'b0;
  logic watchdogTimeout = 1'b0, softResetReq = 1'b0, suspendReq = 1'b0, softOffReq = 1'b0;
  logic power_button_n, reset_button_n, supply_good, mainSupplyLow;
  logic carrier_reset_n, suspend_imminent_n, suspend_to_ram_n, soft_off_state_n;
  logic watchdog_expired;
  mprc_pwr_e powerState;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h000101a0;
  always #10 core_clk = ~core_clk;
  // short presses: the device acts on the edge, not the width
  mprc_carrier #(.PressCyc(40)) carrier (.*);
  module_power_reset_control dut (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitRst(input logic v, input int lim);
    for (int i = 0; i < lim && carrier_reset_n !== v; i++) @(negedge core_clk);
    chk(carrier_reset_n, v);
  endtask
  task automatic waitState(input mprc_pwr_e s, input int lim);
    for (int i = 0; i < lim && powerState !== s; i++) @(negedge core_clk);
    chk({1'b0, powerState}, {1'b0, s});
  endtask
  task automatic pulse(input int which);
    @(negedge core_clk);
    watchdogTimeout = (which == 0);
    softResetReq = (which == 1);
    suspendReq = (which == 2);
    softOffReq = (which == 3);
    wakeReq = (which == 4);
    @(negedge core_clk);
    {watchdogTimeout, softResetReq, suspendReq, softOffReq, wakeReq} = 5'h00;
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    chk({carrier_reset_n, soft_off_state_n, suspend_to_ram_n, watchdog_expired}, 4'h2);
    carrier.press(1'b0, 0);
    waitState(MPRC_RUN, 20);
    waitRst(1'b1, 600);
    fork
      carrier.press(1'b1, 700);
      begin
        repeat (400) @(negedge core_clk);
        chk(carrier_reset_n, 4'h0);
        waitRst(1'b1, 200);
        chk(reset_button_n, 4'h0);
      end
    join
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      repeat (seed[3:0]) @(negedge core_clk);
      pulse(k % 2);
      chk(carrier_reset_n, 4'h0);
      // suspend and soft-off requests are refused while the reset stands
      pulse(2 + k % 2);
      chk({1'b0, powerState}, {1'b0, MPRC_RUN});
      waitRst(1'b1, 600);
      seed = lfsr(seed);
      carrier.dip(seed[0], 5 + seed[6:1]);
      chk(carrier_reset_n, 4'h0);
      waitRst(1'b1, 600);
    end
    chk(watchdog_expired, 4'h1);
    pulse(2);
    chk({suspend_imminent_n, suspend_to_ram_n}, 4'h1);
    // a low enable freezes the lead count
    clkEn = 1'b0;
    repeat (150) @(negedge core_clk);
    chk({1'b0, powerState}, {1'b0, MPRC_PRE_S3});
    clkEn = 1'b1;
    waitState(MPRC_S3, 200);
    chk(suspend_to_ram_n, 4'h0);
    pulse(4);
    waitState(MPRC_RUN, 20);
    chk(suspend_to_ram_n, 4'h1);
    waitRst(1'b1, 600);
    pulse(2);
    waitState(MPRC_S3, 200);
    chk(suspend_to_ram_n, 4'h0);
    carrier.press(1'b0, 0);
    waitState(MPRC_RUN, 20);
    chk(suspend_to_ram_n, 4'h1);
    waitRst(1'b1, 600);
    pulse(3);
    pulse(0);
    chk(carrier_reset_n, 4'h0);
    waitState(MPRC_OFF, 200);
    chk(soft_off_state_n, 4'h0);
    // a mid-run reset clears the sticky watchdog flag
    rst_n = 1'b0;
    @(negedge core_clk);
    chk(watchdog_expired, 4'h0);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk({carrier_reset_n, soft_off_state_n, suspend_to_ram_n, suspend_imminent_n}, 4'h2);
    end_of_test();
  end
endmodule
bind module_power_reset_control mprc_monitor mon (.*);

// ==== mprc_carrier.sv ====
// carrier board model: buttons and main supply
`timescale 1ns/1ps
module mprc_carrier #(
  parameter int PressCyc = 16 * 50000
) (
  // clock
  input  wire logic core_clk,
  // module status
  input  wire logic suspend_to_ram_n,
  // buttons and supply
  output logic      power_button_n,
  output logic      reset_button_n,
  output logic      supply_good,
  output logic      mainSupplyLow
);
  logic atxRailsEnable_n;
  logic supplyOk;
  // inverted suspend output is the active-low enable of the desktop rails
  assign atxRailsEnable_n = ~suspend_to_ram_n;
  // power is good only while the rails are switched on
  assign supply_good      = supplyOk & ~atxRailsEnable_n;
  // released buttons sit at their pull-up level
  initial begin
    power_button_n = 1'b1;
    reset_button_n = 1'b1;
    supplyOk = 1'b1;
    mainSupplyLow = 1'b0;
  end
  task automatic press(input bit rstBtn, input int extra);
    @(negedge core_clk);
    if (rstBtn) reset_button_n = 1'b0; else power_button_n = 1'b0;
    repeat (PressCyc + extra) @(negedge core_clk);
    reset_button_n = 1'b1;
    power_button_n = 1'b1;
  endtask
  task automatic dip(input bit mainLow, input int cyc);
    @(negedge core_clk);
    if (mainLow) mainSupplyLow = 1'b1; else supplyOk = 1'b0;
    repeat (cyc) @(negedge core_clk);
    mainSupplyLow = 1'b0;
    supplyOk = 1'b1;
  endtask
endmodule

// ==== mprc_map.svh ====
// constants for the module power and reset sequencer
`ifndef MPRC_MAP_SVH
`define MPRC_MAP_SVH
`define MPRC_CLK_HZ        50000000
`define MPRC_PRESS_MS      16
`define MPRC_PRESS_CYC     ((`MPRC_CLK_HZ / 1000) * `MPRC_PRESS_MS)
`define MPRC_RST_HOLD_US   10
`define MPRC_RST_HOLD_CYC  ((`MPRC_CLK_HZ / 1000000) * `MPRC_RST_HOLD_US)
`define MPRC_SUS_LEAD_US   2
`define MPRC_SUS_LEAD_CYC  ((`MPRC_CLK_HZ / 1000000) * `MPRC_SUS_LEAD_US)
`define MPRC_CNT_W         20
`endif

// ==== mprc_monitor.sv ====
// concurrent checks on the sequencer's ports
`timescale 1ns/1ps
module mprc_monitor
  import mprc_pkg::*;
(
  // clock, reset, enable
  input wire logic      core_clk,
  input wire logic      rst_n,
  input wire logic      clkEn,
  // pins and events
  input wire logic      power_button_n,
  input wire logic      reset_button_n,
  input wire logic      supply_good,
  input wire logic      mainSupplyLow,
  input wire logic      watchdogTimeout,
  input wire logic      softResetReq,
  // outputs
  input wire logic      carrier_reset_n,
  input wire logic      suspend_imminent_n,
  input wire logic      suspend_to_ram_n,
  input wire logic      soft_off_state_n,
  input wire logic      watchdog_expired,
  input wire mprc_pwr_e powerState
);
  default clocking @(posedge core_clk); endclocking
  // a frozen clock enable stalls every count, so checks pause with it
  default disable iff (!rst_n || !clkEn);
  logic [9:0] lowCnt;
  logic [9:0] next_lowCnt;
  // length of a reset that only a held button could be stretching
  always_comb begin
    next_lowCnt = lowCnt + 10'h1;
    if (carrier_reset_n || reset_button_n || powerState != MPRC_RUN || !supply_good
        || mainSupplyLow || watchdogTimeout || softResetReq || !clkEn) begin
      next_lowCnt = 10'h0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= 10'h0;
    end else begin
      lowCnt <= next_lowCnt;
    end
  end
  property p_wake; $fell(power_button_n) && powerState == MPRC_OFF
    |-> ##[1:4] powerState == MPRC_WAKE; endproperty
  a_wake: assert property (p_wake) else $error("no wake from soft-off");
  property p_btn; $fell(reset_button_n) && powerState == MPRC_RUN
    |-> ##[1:4] !carrier_reset_n; endproperty
  a_btn: assert property (p_btn) else $error("button edge gave no reset");
  property p_hold; lowCnt < 10'h208; endproperty
  a_hold: assert property (p_hold) else $error("held button holds reset");
  property p_evt; watchdogTimeout || softResetReq
    |-> ##[1:2] !carrier_reset_n; endproperty
  a_evt: assert property (p_evt) else $error("event gave no reset");
  property p_sup; (!supply_good || mainSupplyLow) && powerState == MPRC_RUN
    |-> ##[1:4] !carrier_reset_n; endproperty
  a_sup: assert property (p_sup) else $error("supply loss gave no reset");
  property p_wdog; watchdogTimeout || watchdog_expired |=> watchdog_expired; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog flag missing");
  property p_s3; suspend_to_ram_n == (powerState != MPRC_S3)
    && (suspend_to_ram_n || !suspend_imminent_n); endproperty
  a_s3: assert property (p_s3) else $error("suspend output wrong");
  property p_off; soft_off_state_n == (powerState != MPRC_OFF)
    && (soft_off_state_n || !carrier_reset_n); endproperty
  a_off: assert property (p_off) else $error("soft-off output wrong");
  property p_lead; $fell(suspend_imminent_n) && powerState == MPRC_PRE_S3
    |-> suspend_to_ram_n [*8]; endproperty
  a_lead: assert property (p_lead) else $error("no suspend lead");
  property p_rel; $rose(carrier_reset_n) |-> $past(supply_good, 3)
    && !$past(mainSupplyLow, 3) && powerState == MPRC_RUN; endproperty
  a_rel: assert property (p_rel) else $error("reset released early");
  c_wake: cover property (powerState == MPRC_WAKE);
  c_s3: cover property (powerState == MPRC_S3);
  c_rel: cover property ($rose(carrier_reset_n));
endmodule

// ==== mprc_pkg.sv ====
// types for the module power and reset sequencer
package mprc_pkg;
  typedef enum logic [2:0] {
    MPRC_OFF     = 3'h0,
    MPRC_WAKE    = 3'h1,
    MPRC_RUN     = 3'h2,
    MPRC_PRE_S3  = 3'h3,
    MPRC_S3      = 3'h4,
    MPRC_PRE_OFF = 3'h5
  } mprc_pwr_e;
  typedef logic [19:0] mprc_cnt_t;
endpackage

// ==== mprc_sync.sv ====
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ps
module mprc_sync #(
  parameter logic [3:0] IdleLevel = 4'h7
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       clkEn,
  // raw pins
  input wire logic [3:0] rawPins,
  // synchronised levels
  mprc_sync_if.producer  syncOut
);
  logic [3:0] stage1;
  logic [3:0] stage2;
  logic [3:0] next_stage1;
  logic [3:0] next_stage2;

  always_comb begin
    next_stage1 = clkEn ? rawPins : stage1;
    next_stage2 = clkEn ? stage1 : stage2;
  end

  // reset to the idle levels, so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= IdleLevel;
      stage2 <= IdleLevel;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign syncOut.level = stage2;
endmodule

// ==== mprc_sync_if.sv ====
// carrier of synchronised pin levels between sequencer and synchroniser
`timescale 1ns/1ps
interface mprc_sync_if;
  logic [3:0] level;
  modport producer (output level);
  modport consumer (input level);
endinterface
